// ### bench/rtop_chan_model.sv
`timescale 1ns/10ps
`default_nettype none
module rtop_chan_model
(
  // Clock and bench controls
  input  wire logic       clk,
  input  wire logic       sig_on,
  input  wire logic       lock_on,
  input  wire logic [2:0] div_code,
  // Status toward the channel
  output logic            sig_detect_raw,
  output logic            cdr_lock_raw,
  output logic [2:0]      auto_div_code,
  // Sources toward the channel
  output logic            raw_data,
  output logic            retimed_data,
  output logic            in_phase_vco_clock,
  output logic            quadrature_vco_clock,
  output logic            osc_10m
);
  logic [3:0] ph_r = 4'h0;
  // Phase count keeps turning with or without an input
  always @(posedge clk) ph_r <= ph_r + 4'h1;
  // Lock follows the bench only, never the output selector
  assign sig_detect_raw = sig_on;
  assign cdr_lock_raw = sig_on & lock_on;
  assign auto_div_code = div_code;
  // Clocks and data come from one count, so they stay in step
  assign in_phase_vco_clock = ph_r[0];
  assign quadrature_vco_clock = ph_r[0] ^ ph_r[1];
  assign retimed_data = ph_r[1] ^ ph_r[3];
  assign raw_data = ph_r[2] ^ ph_r[0];
  assign osc_10m = ph_r[2];
endmodule : rtop_chan_model
`default_nettype wire

// ### bench/rtop_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rtop_top_chk
  import rtop_pkg::*;
(
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // Register port
  input wire rtop_pkg::rtop_req_type reg_req,
  input wire logic                   reg_valid,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   reg_ready,
  // Channel output and controls
  input wire logic                   out_data,
  input wire logic                   out_mute,
  input wire rtop_pkg::rtop_src_type out_src,
  input wire rtop_pkg::rtop_ana_type ana_ctrl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire logic rd_req = reg_valid && !reg_req.wr;
  wire logic wr_ovr = reg_valid && reg_req.wr && reg_req.addr == RTOP_ADDR_OVR_EN;
  wire logic wr_rsc = reg_valid && reg_req.wr && reg_req.addr == RTOP_ADDR_RAW_RSCH;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  ready_high_a: assert property (reg_ready)
    else $error("register port not ready");
  mute_quiet_a: assert property (out_mute |-> !out_data)
    else $error("data moves while muted");
  chan_off_a: assert property (!ana_ctrl.chan_en [*2] |-> out_mute)
    else $error("disabled channel not muted");
  ovr_clear_a: assert property (wr_ovr && reg_req.wdata == 8'h00 |-> ##2
    !ana_ctrl.cap_ovr && !ana_ctrl.vctl_ovr) else $error("overrides not cancelled");
  cap_ovr_a: assert property (wr_ovr && reg_req.wdata[RTOP_OVR_CAP_BIT] |-> ##2
    ana_ctrl.cap_ovr) else $error("capacitor override not taken");
  vctl_ovr_a: assert property (wr_ovr && reg_req.wdata[RTOP_OVR_VCTL_BIT] |-> ##2
    ana_ctrl.vctl_ovr) else $error("control voltage override not taken");
  rsch_off_a: assert property (wr_rsc && reg_req.wdata[RTOP_RSCH_OFF_BIT] |-> ##2
    ana_ctrl.research_off) else $error("re-search not stopped");
  rdata_hold_a: assert property (!rd_req [*2] |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_rd_a: assert property (rd_req && reg_req.addr == 8'h05 ##1 !rd_req
    |-> ##1 reg_rdata == 8'h00) else $error("unmapped read not zero");
  // Main scenarios reached
  cover property (out_src == RTOP_SRC_PRBS && !out_mute);
  cover property (out_src == RTOP_SRC_RTM && !out_mute);
  cover property (out_src == RTOP_SRC_QCLK && !out_mute);
endmodule : rtop_top_chk
bind rtop_top rtop_top_chk rtop_top_chk_inst
(
  .clk      (clk),
  .rst_n    (rst_n),
  .reg_req  (reg_req),
  .reg_valid(reg_valid),
  .reg_rdata(reg_rdata),
  .reg_ready(reg_ready),
  .out_data (out_data),
  .out_mute (out_mute),
  .out_src  (out_src),
  .ana_ctrl (ana_ctrl)
);
`default_nettype wire

// ### bench/test_retimer_output_path_and_prbs_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_retimer_output_path_and_prbs_control;
  import rtop_pkg::*;
  logic         clk, rst_n, valid, sig_on, lock_on, out_data, out_mute, ready;
  logic [7:0]   rdata, rd_v;
  logic [2:0]   div_code;
  rtop_req_type req;
  rtop_src_type out_src;
  rtop_ana_type ana;
  wire logic    raw, rtm, ick, qck, osc, sd, lk;
  wire logic [2:0] adc;
  int           fail_count, checks_done, cyc, i, k;
  logic         bits [80];
  logic [7:0]   ra [11] = '{8'h08, 8'h09, 8'h0D, 8'h14, 8'h18, 8'h1B, 8'h1E, 8'h1F,
                            8'h30, 8'h3F, 8'h05};
  logic [7:0]   rv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'hE0, 8'h00,
                            8'h00, 8'h00, 8'h00};
  rtop_src_type st [8] = '{RTOP_SRC_MUTE, RTOP_SRC_RTM, RTOP_SRC_ICLK, RTOP_SRC_MUTE,
                           RTOP_SRC_PRBS, RTOP_SRC_10M, RTOP_SRC_MUTE, RTOP_SRC_MUTE};
  // ----------------------------------------------------------------
  // Design and far-side model
  // ----------------------------------------------------------------
  rtop_top rtop_top_inst (.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_valid(valid),
    .reg_rdata(rdata), .reg_ready(ready), .sig_detect_raw(sd), .cdr_lock_raw(lk),
    .auto_div_code(adc), .raw_data(raw), .retimed_data(rtm), .in_phase_vco_clock(ick),
    .quadrature_vco_clock(qck), .osc_10m(osc), .out_data(out_data),
    .out_mute(out_mute), .out_src(out_src), .ana_ctrl(ana));
  rtop_chan_model rtop_chan_model_inst (.clk(clk), .sig_on(sig_on), .lock_on(lock_on),
    .div_code(div_code), .sig_detect_raw(sd), .cdr_lock_raw(lk), .auto_div_code(adc),
    .raw_data(raw), .retimed_data(rtm), .in_phase_vco_clock(ick),
    .quadrature_vco_clock(qck), .osc_10m(osc));
  // ----------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, a, d};
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    req = '{1'b0, a, 8'h00};
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    @(negedge clk);
    rd_v = rdata;
  endtask : rd
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask : chk
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask : settle
  task automatic prbs(input logic [1:0] p);
    wr(8'h1E, 8'h90);
    wr(8'h30, 8'h00);
    wr(8'h30, {6'h00, p});
    wr(8'h30, {4'h0, 1'b1, 1'b0, p});
    wr(8'h0D, 8'h20);
    settle();
    k = 0;
    for (i = 0; i < 80; i++)
    begin
      @(negedge clk);
      bits[i] = out_data;
      k += int'(out_data);
    end
  endtask : prbs
  function automatic logic rec(int l, int t);
    for (int n = l; n < 80; n++)
      if (bits[n] !== (bits[n-l] ^ bits[n-t])) return 1'b0;
    return 1'b1;
  endfunction : rec
  task conclude;
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      fail_count++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0; valid = 1'b0; req = '0; sig_on = 1'b0; lock_on = 1'b0; div_code = 3'h0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    for (int j = 0; j < 11; j++)
    begin
      rd(ra[j]);
      chk(rd_v, rv[j], "reset value");
    end
    wr(8'h05, 8'hFF);
    rd(8'h05);
    chk(rd_v, 8'h00, "unmapped");
    chk({7'h00, out_mute}, 8'h01, "no signal mute");
    sig_on = 1'b1;
    settle();
    chk({7'h00, out_mute}, 8'h01, "unlocked default");
    wr(8'h1E, 8'h00);
    settle();
    chk({5'h00, out_src}, {5'h00, RTOP_SRC_RAW}, "raw bypass");
    chk({7'h00, out_mute}, 8'h00, "raw bypass live");
    lock_on = 1'b1;
    settle();
    chk({5'h00, out_src}, {5'h00, RTOP_SRC_RTM}, "locked");
    wr(8'h09, 8'h20);
    for (int l = 1; l >= 0; l--)
    begin
      lock_on = l[0];
      for (int c = 0; c < 8; c++)
      begin
        wr(8'h1E, {c[2:0], 5'h00});
        settle();
        chk({7'h00, out_mute}, {7'h00, st[c] == RTOP_SRC_MUTE}, "mute");
        if (st[c] != RTOP_SRC_MUTE) chk({5'h00, out_src}, {5'h00, st[c]}, "src");
      end
    end
    wr(8'h3F, 8'h80);
    wr(8'h1E, 8'h00);
    settle();
    chk({7'h00, out_mute}, 8'h00, "raw kept live");
    wr(8'h09, 8'h30);
    wr(8'h1E, 8'h61);
    settle();
    chk({5'h00, out_src}, {5'h00, RTOP_SRC_QCLK}, "quadrature");
    sig_on = 1'b0;
    settle();
    chk({7'h00, out_mute}, 8'h01, "signal lost");
    wr(8'h14, 8'h80);
    settle();
    chk({7'h00, ana.chan_en}, 8'h01, "forced on");
    chk({7'h00, out_mute}, 8'h00, "forced live");
    wr(8'h14, 8'h00);
    settle();
    chk({7'h00, ana.chan_en}, 8'h00, "detect returned");
    wr(8'h14, 8'h80);
    prbs(RTOP_PAT_NINE);
    chk({5'h00, out_src}, {5'h00, RTOP_SRC_PRBS}, "pattern routed");
    chk({7'h00, rec(9, 5) | rec(9, 4)}, 8'h01, "nine-bit pattern");
    chk({7'h00, k > 0 && k < 80}, 8'h01, "nine-bit moving");
    prbs(RTOP_PAT_THIRTY_ONE);
    chk({7'h00, rec(31, 28) | rec(31, 3)}, 8'h01, "long pattern");
    chk({7'h00, k > 0 && k < 80}, 8'h01, "long moving");
    wr(8'h09, 8'h04);
    for (int c = 0; c < 5; c++)
    begin
      wr(8'h18, {1'b0, c[2:0], 4'h0});
      settle();
      chk({3'h0, ana.div_ratio}, 8'h01 << c, "divider override");
    end
    wr(8'h09, 8'h00);
    div_code = 3'h3;
    settle();
    settle();
    chk({3'h0, ana.div_ratio}, 8'h08, "divider auto");
    wr(8'h09, 8'h08);
    wr(8'h1B, 8'h00);
    wr(8'h09, 8'h8C);
    wr(8'h08, 8'h08);
    wr(8'h09, 8'hCC);
    wr(8'h1F, 8'h12);
    settle();
    chk({7'h00, ana.cp_en}, 8'h00, "pump off");
    chk({3'h0, ana.cap_val}, 8'h08, "cap value");
    chk({3'h0, ana.vctl_val}, 8'h12, "voltage value");
    rd(8'h09);
    chk(rd_v, 8'hCC, "override bits kept");
    wr(8'h09, 8'h00);
    settle();
    chk({7'h00, ana.cap_ovr | ana.vctl_ovr}, 8'h00, "all cancelled");
    chk({7'h00, ana.cp_en}, 8'h01, "pump back");
    conclude();
  end
endmodule : test_retimer_output_path_and_prbs_control
`default_nettype wire

// ### src/rtop_pkg.sv
package rtop_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RTOP_ADDR_CAP_OVR   = 8'h08;
  localparam logic [7:0] RTOP_ADDR_OVR_EN    = 8'h09;
  localparam logic [7:0] RTOP_ADDR_PRBS_CLK  = 8'h0D;
  localparam logic [7:0] RTOP_ADDR_SD_FORCE  = 8'h14;
  localparam logic [7:0] RTOP_ADDR_DIV_SEL   = 8'h18;
  localparam logic [7:0] RTOP_ADDR_CP_CTRL   = 8'h1B;
  localparam logic [7:0] RTOP_ADDR_OUT_SEL   = 8'h1E;
  localparam logic [7:0] RTOP_ADDR_VCTL      = 8'h1F;
  localparam logic [7:0] RTOP_ADDR_PRBS_PAT  = 8'h30;
  localparam logic [7:0] RTOP_ADDR_RAW_RSCH  = 8'h3F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RTOP_OVR_CAP_BIT   = 7;
  localparam int RTOP_OVR_VCTL_BIT  = 6;
  localparam int RTOP_OVR_MUX_BIT   = 5;
  localparam int RTOP_OVR_QCLK_BIT  = 4;
  localparam int RTOP_OVR_CP_BIT    = 3;
  localparam int RTOP_OVR_DIV_BIT   = 2;
  localparam int RTOP_MUX_MSB       = 7;
  localparam int RTOP_MUX_LSB       = 5;
  localparam int RTOP_PRBS_EN_BIT   = 4;
  localparam int RTOP_QCLK_EN_BIT   = 0;
  localparam int RTOP_PRBS_LOAD_BIT = 3;
  localparam int RTOP_PRBS_CLK_BIT  = 5;
  localparam int RTOP_SD_ON_BIT     = 7;
  localparam int RTOP_SD_OFF_BIT    = 6;
  localparam int RTOP_DIV_MSB       = 6;
  localparam int RTOP_DIV_LSB       = 4;
  localparam int RTOP_RSCH_OFF_BIT  = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RTOP_RST_ZERO    = 8'h00;
  localparam logic [7:0] RTOP_RST_OUT_SEL = 8'hE0;  // Mute select, PRBS off
  localparam logic [7:0] RTOP_RST_CP      = 8'h03;  // Charge pump on

  // ----------------------------------------------------------------
  // Output select codes and pattern codes
  // ----------------------------------------------------------------
  localparam logic [2:0] RTOP_SEL_RAW   = 3'h0;
  localparam logic [2:0] RTOP_SEL_RTM   = 3'h1;
  localparam logic [2:0] RTOP_SEL_ICLK  = 3'h2;
  localparam logic [2:0] RTOP_SEL_QCLK  = 3'h3;
  localparam logic [2:0] RTOP_SEL_PRBS  = 3'h4;
  localparam logic [2:0] RTOP_SEL_10M   = 3'h5;
  localparam logic [2:0] RTOP_SEL_BAD   = 3'h6;
  localparam logic [2:0] RTOP_SEL_MUTE  = 3'h7;
  localparam logic [1:0] RTOP_PAT_NINE  = 2'h0;
  localparam logic [1:0] RTOP_PAT_THIRTY_ONE = 2'h2;
  localparam logic [2:0] RTOP_DIV_MAX_CODE = 3'h4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RTOP_SRC_MUTE,
    RTOP_SRC_RAW,
    RTOP_SRC_RTM,
    RTOP_SRC_ICLK,
    RTOP_SRC_QCLK,
    RTOP_SRC_PRBS,
    RTOP_SRC_10M
  } rtop_src_type;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtop_req_type;

  // Analog control bundle toward the VCO and loop
  typedef struct packed {
    logic       cap_ovr;
    logic [4:0] cap_val;
    logic       vctl_ovr;
    logic [4:0] vctl_val;
    logic       cp_en;
    logic [4:0] div_ratio;
    logic       research_off;
    logic       chan_en;
  } rtop_ana_type;

endpackage : rtop_pkg

// ### src/rtop_prbs.sv
`timescale 1ns/10ps
`default_nettype none

module rtop_prbs
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       dig_en,
  input  wire logic       load,
  input  wire logic       run,
  input  wire logic [1:0] pattern,
  // Output
  output logic            bit_out
);
  import rtop_pkg::*;

  logic [30:0] lfsr_r;
  logic [30:0] lfsr_nxt;
  logic        fb_nine;
  logic        fb_long;
  logic        bit_r;

  // Feedback taps for the two polynomials
  assign fb_nine  = lfsr_r[8] ^ lfsr_r[4];
  assign fb_long  = lfsr_r[30] ^ lfsr_r[27];
  assign lfsr_nxt = (pattern == RTOP_PAT_THIRTY_ONE) ?
                    {lfsr_r[29:0], fb_long} :
                    {lfsr_r[30:9], lfsr_r[7:0], fb_nine};

  // Shift register; load low holds it at the all-ones seed
  always_ff @(posedge clk)
  begin
    if (!rst_n || !dig_en || !load)
      lfsr_r <= {31{1'b1}};
    else if (run)
      lfsr_r <= lfsr_nxt;
  end

  // Registered serial output
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bit_r <= 1'b0;
    else
      bit_r <= (pattern == RTOP_PAT_THIRTY_ONE) ? lfsr_r[30] : lfsr_r[8];
  end

  assign bit_out = bit_r;

endmodule : rtop_prbs
`default_nettype wire

// ### src/rtop_top.sv
// What this block does
// - Override clear: select field picks output when signal present but unlocked; 7 mutes.
// - Override clear and field zero: raw data sent whenever channel unlocked.
// - Override set: output is always the selected source regardless of lock.
// - Re-search disable bit stops cap re-search so raw bypass is not muted.
// - No detected signal powers down channel; output muted unless detect forced.
// - 0x14 bit 7 set, bit 6 clear forces signal detect and enables channel.
// - 0x14 bits 7 and 6 clear return detect to the internal circuitry.
// - Without input the VCO free-runs at divider and capacitor settings.
// - Override active: free-running 10 MHz clock can always be selected.
// - Locked: VCO clocks and PRBS output are synchronous to the input.
// - Without override the divide ratio follows the detected bit rate.
// - 0x09 bit 2 set: ratio from 0x18 bits 6:4, codes 0-4 give 1-16.
// - Pattern field 0 gives nine-bit, 2 gives thirty-one-bit pattern.
// - Lock is kept whichever source the output selector drives.
// - 0x09 bit 3 plus 0x1b bits 1:0 zero disable the charge pump.
// - 0x09 bit 7 enables capacitor override taken from 0x08 bits 4:0.
// - 0x09 bit 6 enables control-voltage DAC from 0x1f bits 4:0.
// - Override register resets to zero; writing zero cancels every override.
// - Select codes: 7 mute, 6 invalid, 5 oscillator, 4 pattern, 3/2 clocks, 1/0 data.
// - Quadrature clock only when 0x09 bit 4 and 0x1e bit 0 are set.
`timescale 1ns/10ps
`default_nettype none

module rtop_top
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Register port
  input  wire rtop_pkg::rtop_req_type reg_req,
  input  wire logic                  reg_valid,
  output logic [7:0]                 reg_rdata,
  output logic                       reg_ready,
  // Channel status from the analog side (asynchronous)
  input  wire logic                  sig_detect_raw,
  input  wire logic                  cdr_lock_raw,
  input  wire logic [2:0]            auto_div_code,
  // Data and clock sources, already in this domain
  input  wire logic                  raw_data,
  input  wire logic                  retimed_data,
  input  wire logic                  in_phase_vco_clock,
  input  wire logic                  quadrature_vco_clock,
  input  wire logic                  osc_10m,
  // Channel output
  output logic                       out_data,
  output logic                       out_mute,
  output rtop_pkg::rtop_src_type     out_src,
  // Analog controls
  output rtop_pkg::rtop_ana_type     ana_ctrl
);
  import rtop_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] cap_r, ovr_r, pclk_r, sdf_r, div_r, cp_r, osel_r, vctl_r, ppat_r, rsch_r;
  logic [7:0] rdata_r;
  logic       wr_en;

  // Writes land on any valid cycle; the port never stalls
  assign wr_en     = reg_valid && reg_req.wr;
  assign reg_ready = 1'b1;

  // Byte-wide register writes; reset sets every override cleared
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cap_r  <= RTOP_RST_ZERO;
      ovr_r  <= RTOP_RST_ZERO;
      pclk_r <= RTOP_RST_ZERO;
      sdf_r  <= RTOP_RST_ZERO;
      div_r  <= RTOP_RST_ZERO;
      cp_r   <= RTOP_RST_CP;
      osel_r <= RTOP_RST_OUT_SEL;
      vctl_r <= RTOP_RST_ZERO;
      ppat_r <= RTOP_RST_ZERO;
      rsch_r <= RTOP_RST_ZERO;
    end
    else if (wr_en)
    begin
      unique case (reg_req.addr)
        RTOP_ADDR_CAP_OVR:  cap_r  <= reg_req.wdata;
        RTOP_ADDR_OVR_EN:   ovr_r  <= reg_req.wdata;
        RTOP_ADDR_PRBS_CLK: pclk_r <= reg_req.wdata;
        RTOP_ADDR_SD_FORCE: sdf_r  <= reg_req.wdata;
        RTOP_ADDR_DIV_SEL:  div_r  <= reg_req.wdata;
        RTOP_ADDR_CP_CTRL:  cp_r   <= reg_req.wdata;
        RTOP_ADDR_OUT_SEL:  osel_r <= reg_req.wdata;
        RTOP_ADDR_VCTL:     vctl_r <= reg_req.wdata;
        RTOP_ADDR_PRBS_PAT: ppat_r <= reg_req.wdata;
        RTOP_ADDR_RAW_RSCH: rsch_r <= reg_req.wdata;
        default:            ;
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  logic [7:0] rd_sel;
  always_comb
  begin
    unique case (reg_req.addr)
      RTOP_ADDR_CAP_OVR:  rd_sel = cap_r;
      RTOP_ADDR_OVR_EN:   rd_sel = ovr_r;
      RTOP_ADDR_PRBS_CLK: rd_sel = pclk_r;
      RTOP_ADDR_SD_FORCE: rd_sel = sdf_r;
      RTOP_ADDR_DIV_SEL:  rd_sel = div_r;
      RTOP_ADDR_CP_CTRL:  rd_sel = cp_r;
      RTOP_ADDR_OUT_SEL:  rd_sel = osel_r;
      RTOP_ADDR_VCTL:     rd_sel = vctl_r;
      RTOP_ADDR_PRBS_PAT: rd_sel = ppat_r;
      RTOP_ADDR_RAW_RSCH: rd_sel = rsch_r;
      default:            rd_sel = RTOP_RST_ZERO;
    endcase
  end

  // Registered read data, one cycle after a valid read
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_r <= RTOP_RST_ZERO;
    else if (reg_valid && !reg_req.wr)
      rdata_r <= rd_sel;
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Status synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sd_meta_r, sd_sync_r;
  logic [2:0] ad_meta_r, ad_sync_r, ad_prev_r, ad_stab_r;
  logic [2:0] ad_stab_nxt;

  // Two flops on every asynchronous status input
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sd_meta_r <= 2'h0;
      sd_sync_r <= 2'h0;
      ad_meta_r <= 3'h0;
      ad_sync_r <= 3'h0;
      ad_prev_r <= 3'h0;
      ad_stab_r <= 3'h0;
    end
    else
    begin
      sd_meta_r <= {cdr_lock_raw, sig_detect_raw};
      sd_sync_r <= sd_meta_r;
      ad_meta_r <= auto_div_code;
      ad_sync_r <= ad_meta_r;
      ad_prev_r <= ad_sync_r;
      ad_stab_r <= ad_stab_nxt;
    end
  end

  // Rate code is several bits wide: it is taken only once two
  // samples agree, so a code caught mid-change never reaches the divider
  assign ad_stab_nxt = (ad_sync_r == ad_prev_r) ? ad_sync_r : ad_stab_r;

  // Synchronised status bits
  logic sig_det_s, lock_s;
  assign sig_det_s = sd_sync_r[0];
  assign lock_s    = sd_sync_r[1];

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  logic       sd_force_on, sd_force_off, chan_en, mux_ovr, raw_hold;
  logic [2:0] sel_code, div_code;

  // Signal-detect force pair; the other two combinations leave detection alone
  assign sd_force_on  = sdf_r[RTOP_SD_ON_BIT] && !sdf_r[RTOP_SD_OFF_BIT];
  assign sd_force_off = !sdf_r[RTOP_SD_ON_BIT] && sdf_r[RTOP_SD_OFF_BIT];
  // Device detection when neither bit forces a state
  assign chan_en      = sd_force_on || (!sd_force_off && sig_det_s);
  assign mux_ovr      = ovr_r[RTOP_OVR_MUX_BIT];
  assign sel_code     = osel_r[RTOP_MUX_MSB:RTOP_MUX_LSB];
  assign raw_hold     = rsch_r[RTOP_RSCH_OFF_BIT];

  // Decode of a select code into a source
  function automatic rtop_src_type sel_decode(input logic [2:0] code, input logic q_ok);
    unique case (code)
      RTOP_SEL_RAW:  sel_decode = RTOP_SRC_RAW;
      RTOP_SEL_RTM:  sel_decode = RTOP_SRC_RTM;
      RTOP_SEL_ICLK: sel_decode = RTOP_SRC_ICLK;
      RTOP_SEL_QCLK: sel_decode = q_ok ? RTOP_SRC_QCLK : RTOP_SRC_MUTE;
      RTOP_SEL_PRBS: sel_decode = RTOP_SRC_PRBS;
      RTOP_SEL_10M:  sel_decode = RTOP_SRC_10M;
      RTOP_SEL_BAD:  sel_decode = RTOP_SRC_MUTE;
      RTOP_SEL_MUTE: sel_decode = RTOP_SRC_MUTE;
    endcase
  endfunction : sel_decode

  logic         q_ok;
  rtop_src_type sel_src, src_nxt;
  // Quadrature clock needs both of its enables
  assign q_ok    = ovr_r[RTOP_OVR_QCLK_BIT] && osel_r[RTOP_QCLK_EN_BIT];
  assign sel_src = sel_decode(sel_code, q_ok);

  // Source choice: override forces selection, else lock picks retimed
  assign src_nxt = !chan_en ? RTOP_SRC_MUTE :
                   mux_ovr  ? sel_src :
                   lock_s   ? RTOP_SRC_RTM : sel_src;

  // Raw bypass under mux override is muted by re-search unless the hold bit is set
  logic mute_nxt;
  assign mute_nxt = (src_nxt == RTOP_SRC_MUTE) ||
                    (src_nxt == RTOP_SRC_RAW && mux_ovr && !raw_hold);

  // ----------------------------------------------------------------
  // Pattern generator
  // ----------------------------------------------------------------
  logic prbs_bit;
  // Generator steps on this clock, which follows the VCO when locked
  rtop_prbs rtop_prbs_inst
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .dig_en  (osel_r[RTOP_PRBS_EN_BIT]),
    .load    (ppat_r[RTOP_PRBS_LOAD_BIT]),
    .run     (pclk_r[RTOP_PRBS_CLK_BIT]),
    .pattern (ppat_r[1:0]),
    .bit_out (prbs_bit)
  );

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  logic         data_nxt;
  logic         out_r, mute_r;
  rtop_src_type src_r;

  // Data mux; the VCO sources stay in their own phase when locked
  always_comb
  begin
    unique case (src_nxt)
      RTOP_SRC_RAW:  data_nxt = raw_data;
      RTOP_SRC_RTM:  data_nxt = retimed_data;
      RTOP_SRC_ICLK: data_nxt = in_phase_vco_clock;
      RTOP_SRC_QCLK: data_nxt = quadrature_vco_clock;
      RTOP_SRC_PRBS: data_nxt = prbs_bit;
      RTOP_SRC_10M:  data_nxt = osc_10m;
      default:       data_nxt = 1'b0;
    endcase
  end

  // Output flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_r  <= 1'b0;
      mute_r <= 1'b1;
      src_r  <= RTOP_SRC_MUTE;
    end
    else
    begin
      out_r  <= mute_nxt ? 1'b0 : data_nxt;
      mute_r <= mute_nxt;
      src_r  <= src_nxt;
    end
  end

  assign out_data = out_r;
  assign out_mute = mute_r;
  assign out_src  = src_r;

  // ----------------------------------------------------------------
  // VCO and loop controls
  // ----------------------------------------------------------------
  // Divider code: override field or rate-derived code, clamped to 16
  logic [2:0] div_pick;
  assign div_pick = ovr_r[RTOP_OVR_DIV_BIT] ? div_r[RTOP_DIV_MSB:RTOP_DIV_LSB]
                                            : ad_stab_r;
  assign div_code = (div_pick > RTOP_DIV_MAX_CODE) ? RTOP_DIV_MAX_CODE : div_pick;

  // Analog bundle; lock is not disturbed by the output choice
  logic cp_off;
  assign cp_off = ovr_r[RTOP_OVR_CP_BIT] && (cp_r[1:0] == 2'h0);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ana_ctrl <= '0;
    else
    begin
      ana_ctrl.cap_ovr      <= ovr_r[RTOP_OVR_CAP_BIT];
      ana_ctrl.cap_val      <= cap_r[4:0];
      ana_ctrl.vctl_ovr     <= ovr_r[RTOP_OVR_VCTL_BIT];
      ana_ctrl.vctl_val     <= vctl_r[4:0];
      ana_ctrl.cp_en        <= !cp_off;
      ana_ctrl.div_ratio    <= 5'(5'h01 << div_code);
      ana_ctrl.research_off <= raw_hold;
      ana_ctrl.chan_en      <= chan_en;
    end
  end

endmodule : rtop_top
`default_nettype wire
